/* File: sfwdg_top.sv */
// software fault watchdog with AHB-Lite register access
//
// What this block does
// - while running, decrement alive+countdown counter every 3072 core clocks
// - timeout selectable in 64 steps, one decrement interval each
// - hardwired option keeps watchdog active, enable bit forced high
// - software option: off after reset, enabled once by software until reset
// - enabled and alive bit zero starts a reset pulse of about 500ns
// - clearing alive bit while enabled gives a software reset
// - disabled counter still runs as a 7-bit timer, bits reversed
// - at 8 MHz one decrement every 384 us, 0.384 to 24.576 ms
// - wait state leaves watchdog counting and resetting normally
// - disabled watchdog: stop instruction gives full stop
// - enabled, no external halt control: stop becomes wait
// - enabled with external halt control: stop if interrupt pin high, else wait
// - interrupt out of stop resumes counting from frozen value
// - register at 0D8h, readable and writable, resets to FEh
//
// Chosen here: the placing of the registers and the AHB-Lite interface to the registers.
`default_nettype none
module sfwdg_top #(
    parameter int STEP_LEN = sfwdg_pkg::STEP_CYCLES,
    parameter int PULSE_LEN = sfwdg_pkg::PULSE_CYCLES
) (
    // clock and reset
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic clkEn,
    // ahb-lite slave
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    // option straps
    input wire logic hardwiredActivationOption,
    input wire logic externalHaltControlOption,
    // core side
    input wire logic stopRequest,
    input wire logic wakeInterrupt,
    input wire logic nmiPin,
    // outputs
    output logic resetPinN,
    output logic haltStop,
    output logic haltWait,
    output logic irq
);
    // the prescaler is sixteen bits wide
    if (STEP_LEN < 1 || STEP_LEN > 65535) begin : g_bad_step
        $error("step length out of range");
    end

    function automatic logic [5:0] bitrev6(input logic [5:0] v);
        for (int i = 0; i < 6; i++) begin
            bitrev6[i] = v[5 - i];
        end
    endfunction : bitrev6

    ////////////////////////////////////////////////////////////////////////////
    // pin synchronisers and strap capture
    logic [1:0] nmiSync_q;
    logic [1:0] hwOptSync_q, extOptSync_q;
    logic hwOpt_q, extOpt_q;
    logic [1:0] strapAge_q;

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            nmiSync_q <= 2'b00;
            hwOptSync_q <= 2'b00;
            extOptSync_q <= 2'b00;
        end else if (clkEn) begin
            nmiSync_q <= {nmiSync_q[0], nmiPin};
            hwOptSync_q <= {hwOptSync_q[0], hardwiredActivationOption};
            extOptSync_q <= {extOptSync_q[0], externalHaltControlOption};
        end
    end

    // straps latched once, at the third edge after release, when the synchronisers hold them
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            hwOpt_q <= 1'b0;
            extOpt_q <= 1'b0;
            strapAge_q <= 2'b00;
        end else if (clkEn && strapAge_q != 2'b11) begin
            strapAge_q <= strapAge_q + 2'b01;
            if (strapAge_q == 2'b10) begin
                hwOpt_q <= hwOptSync_q[1];
                extOpt_q <= extOptSync_q[1];
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // ahb-lite address phase capture
    logic wrPend_q, wrPend_d, rdPend_q, rdPend_d;
    logic [7:0] addr_q, addr_d;
    logic take;

    assign take = hsel && hready && htrans[1];

    always_comb begin
        wrPend_d = take && hwrite;
        rdPend_d = take && !hwrite;
        addr_d = take ? haddr[7:0] : addr_q;
    end

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            wrPend_q <= 1'b0;
            rdPend_q <= 1'b0;
            addr_q <= 8'h00;
        end else if (clkEn) begin
            wrPend_q <= wrPend_d;
            rdPend_q <= rdPend_d;
            addr_q <= addr_d;
        end
    end

    assign hreadyout = 1'b1;
    assign hresp = 1'b0;

    logic wrGuard, wrMask, rdStat;
    assign wrGuard = wrPend_q && addr_q == sfwdg_pkg::GUARD_OFS;
    assign wrMask = wrPend_q && addr_q == sfwdg_pkg::MASK_OFS;
    assign rdStat = rdPend_q && addr_q == sfwdg_pkg::STAT_OFS;

    ////////////////////////////////////////////////////////////////////////////
    // guard timer, prescaler and halt state
    sfwdg_if lnk ();
    logic [7:0] guard_q, guard_d;
    logic [15:0] pre_q, pre_d;
    logic frozen_q, frozen_d;
    logic enabled, tick, expire, swReset, haltIsStop, haltIsWait;
    logic [6:0] cnt, cntNext;
    sfwdg_pkg::sfwdg_halt_t halt;

    assign enabled = guard_q[sfwdg_pkg::ENABLE_BIT] | hwOpt_q;
    // counter: alive bit is msb, countdown lsb sits in bit 7
    assign cnt = {guard_q[sfwdg_pkg::ALIVE_BIT], bitrev6(guard_q[7:sfwdg_pkg::COUNT_LSB])};
    assign cntNext = cnt - 7'h01;
    assign tick = !frozen_q && pre_q == 16'(STEP_LEN - 1);

    always_comb begin
        halt = sfwdg_pkg::SFWDG_RUN;
        if (stopRequest) begin
            if (!enabled) begin
                halt = sfwdg_pkg::SFWDG_STOP;
            end else if (!extOpt_q) begin
                halt = sfwdg_pkg::SFWDG_WAIT;
            end else if (nmiSync_q[1]) begin
                halt = sfwdg_pkg::SFWDG_STOP;
            end else begin
                halt = sfwdg_pkg::SFWDG_WAIT;
            end
        end
    end

    assign haltIsStop = halt == sfwdg_pkg::SFWDG_STOP;
    assign haltIsWait = halt == sfwdg_pkg::SFWDG_WAIT;

    always_comb begin
        guard_d = guard_q;
        pre_d = tick ? 16'h0000 : (frozen_q ? pre_q : pre_q + 16'h0001);
        frozen_d = frozen_q;
        if (haltIsStop && enabled) begin
            frozen_d = 1'b1;
        end
        if (frozen_q && wakeInterrupt) begin
            frozen_d = 1'b0;
        end
        if (wrGuard) begin
            guard_d = hwdata[7:0];
            guard_d[sfwdg_pkg::ENABLE_BIT] = hwdata[sfwdg_pkg::ENABLE_BIT] | enabled;
        end else if (tick && !lnk.busy) begin
            guard_d = {bitrev6(cntNext[5:0]), cntNext[6], guard_q[0]};
        end
        if (hwOpt_q) begin
            guard_d[sfwdg_pkg::ENABLE_BIT] = 1'b1;
        end
    end

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            guard_q <= sfwdg_pkg::GUARD_RESET;
            pre_q <= 16'h0000;
            frozen_q <= 1'b0;
        end else if (clkEn) begin
            guard_q <= guard_d;
            pre_q <= pre_d;
            frozen_q <= frozen_d;
        end
    end

    // reset trigger when alive bit is zero while enabled
    assign expire = enabled && !guard_q[sfwdg_pkg::ALIVE_BIT] && !lnk.busy;
    assign swReset = wrGuard && !hwdata[sfwdg_pkg::ALIVE_BIT] && enabled;
    assign lnk.fire = expire;

    sfwdg_pulse #(.PULSE_LEN(PULSE_LEN)) u_pulse (
        .sys_clk(sys_clk),
        .rst(rst),
        .clkEn(clkEn),
        .pl(lnk.pulse)
    );

    ////////////////////////////////////////////////////////////////////////////
    // interrupt status, mask and read data
    logic [sfwdg_pkg::EV_WIDTH-1:0] stat_q, stat_d, mask_q, mask_d, events;
    logic [31:0] rdata_q, rdata_d;
    logic resetN_q, stop_q, wait_q;

    assign events = {haltIsStop, swReset, expire};

    always_comb begin
        // only bits handed out by the read are cleared; set wins over clear
        stat_d = (rdStat ? (stat_q & ~rdata_q[sfwdg_pkg::EV_WIDTH-1:0]) : stat_q) | events;
        mask_d = wrMask ? hwdata[sfwdg_pkg::EV_WIDTH-1:0] : mask_q;
        rdata_d = 32'h0000_0000;
        if (take && !hwrite) begin
            unique case (haddr[7:0])
                sfwdg_pkg::GUARD_OFS: rdata_d = {24'h000000, guard_q};
                sfwdg_pkg::STAT_OFS: rdata_d = {29'h0, stat_q};
                sfwdg_pkg::MASK_OFS: rdata_d = {29'h0, mask_q};
                sfwdg_pkg::CTRL_OFS: rdata_d = {28'h0, frozen_q, nmiSync_q[1], extOpt_q, hwOpt_q};
                default: rdata_d = 32'h0000_0000;
            endcase
        end
    end

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            stat_q <= '0;
            mask_q <= '0;
            rdata_q <= 32'h0000_0000;
            resetN_q <= 1'b1;
            stop_q <= 1'b0;
            wait_q <= 1'b0;
        end else if (clkEn) begin
            stat_q <= stat_d;
            mask_q <= mask_d;
            rdata_q <= rdata_d;
            resetN_q <= !lnk.resetOut;
            stop_q <= haltIsStop;
            wait_q <= haltIsWait;
        end
    end

    assign hrdata = rdata_q;
    assign irq = |(stat_q & mask_q);
    assign resetPinN = resetN_q;
    assign haltStop = stop_q;
    assign haltWait = wait_q;
endmodule : sfwdg_top
`default_nettype wire

/* File: sfwdg_pkg.sv */
// shared constants for the software fault watchdog
`default_nettype none
package sfwdg_pkg;
    // bus register map (word offsets as byte addresses)
    localparam logic [7:0] GUARD_OFS = 8'hd8;
    localparam logic [7:0] STAT_OFS = 8'hdc;
    localparam logic [7:0] MASK_OFS = 8'he0;
    localparam logic [7:0] CTRL_OFS = 8'he4;
    // guard timer register fields
    localparam int ENABLE_BIT = 0;
    localparam int ALIVE_BIT = 1;
    localparam int COUNT_LSB = 2;
    localparam logic [7:0] GUARD_RESET = 8'hfe;
    // event bits in status and mask
    localparam int EV_EXPIRE = 0;
    localparam int EV_SWRESET = 1;
    localparam int EV_STOP = 2;
    localparam int EV_WIDTH = 3;
    // timing
    localparam int CLK_HZ = 25000000;
    localparam int STEP_CYCLES = 3072;
    localparam int PULSE_NS = 500;
    localparam int PULSE_CYCLES = (PULSE_NS * (CLK_HZ / 1000000)) / 1000;
    localparam int COUNT_STEPS = 64;
    // halt decision outcomes
    typedef enum logic [1:0] {SFWDG_RUN, SFWDG_WAIT, SFWDG_STOP} sfwdg_halt_t;
endpackage : sfwdg_pkg
`default_nettype wire

/* File: sfwdg_if.sv */
// carrier between the watchdog core and its reset pulse stretcher
`default_nettype none
interface sfwdg_if;
    logic fire;
    logic busy;
    logic resetOut;
    modport core (output fire, input busy, input resetOut);
    modport pulse (input fire, output busy, output resetOut);
endinterface : sfwdg_if
`default_nettype wire

/* File: sfwdg_pulse.sv */
// reset pulse stretcher: holds reset low for a counted number of cycles
`default_nettype none
module sfwdg_pulse #(
    parameter int PULSE_LEN = sfwdg_pkg::PULSE_CYCLES
) (
    // clock and reset
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic clkEn,
    // link to core
    sfwdg_if.pulse pl
);
    logic [7:0] cnt_q, cnt_d;

    // the counter is eight bits wide
    if (PULSE_LEN < 1 || PULSE_LEN > 255) begin : g_bad_pulse
        $error("pulse length out of range");
    end

    always_comb begin
        cnt_d = cnt_q;
        if (cnt_q != 8'h00) begin
            cnt_d = cnt_q - 8'h01;
        end else if (pl.fire) begin
            cnt_d = 8'(PULSE_LEN);
        end
    end

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            cnt_q <= 8'h00;
        end else if (clkEn) begin
            cnt_q <= cnt_d;
        end
    end

    assign pl.busy = (cnt_q != 8'h00);
    assign pl.resetOut = (cnt_q != 8'h00);
endmodule : sfwdg_pulse
`default_nettype wire

/* File: sfwdg_assertions.sv */
// port checker for the software fault watchdog
`default_nettype none
module sfwdg_assertions #(
    parameter int PULSE_LEN = sfwdg_pkg::PULSE_CYCLES
) (
    // clock and reset
    input wire logic sys_clk,
    input wire logic rst,
    // watched ports
    input wire logic hresp,
    input wire logic hreadyout,
    input wire logic resetPinN,
    input wire logic haltStop,
    input wire logic haltWait,
    input wire logic stopRequest
);
    int lowCnt_q;
    int lowCnt_d;
    always_comb lowCnt_d = resetPinN ? 0 : lowCnt_q + 1;
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) lowCnt_q <= 0;
        else lowCnt_q <= lowCnt_d;
    end
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (rst);
    ////////////////////////////////////////
    a_resp_okay: assert property (hresp == 1'b0)
        else $error("response not okay");
    a_ready_high: assert property (hreadyout == 1'b1)
        else $error("ready low");
    a_pulse_len: assert property ($rose(resetPinN) |-> lowCnt_q == PULSE_LEN)
        else $error("pulse length wrong");
    a_pulse_cap: assert property (lowCnt_q <= PULSE_LEN)
        else $error("pulse too long");
    a_halt_excl: assert property (!(haltStop && haltWait))
        else $error("stop and wait together");
    a_stop_cause: assert property ($rose(haltStop) |-> $past(stopRequest))
        else $error("stop without request");
    a_wait_cause: assert property ($rose(haltWait) |-> $past(stopRequest))
        else $error("wait without request");
    a_wait_drop: assert property ($fell(stopRequest) |-> ##[0:2] !haltWait)
        else $error("wait stuck");
    c_pulse: cover property ($fell(resetPinN));
    c_stop: cover property ($rose(haltStop));
    c_wait: cover property ($rose(haltWait));
endmodule : sfwdg_assertions
`default_nettype wire

/* File: sfwdg_top_tb.sv */
// testbench for the software fault watchdog
`default_nettype none
module sfwdg_top_tb;
    timeunit 1ns;
    timeprecision 1ns;
    logic sys_clk = 0, rst = 1, hsel = 0, hwrite = 0, stopRequest = 0;
    logic wakeInterrupt = 0, nmiPin = 0, clkEn = 1;
    logic hardwiredActivationOption = 0, externalHaltControlOption = 0;
    logic [1:0] htrans = 2'h0;
    logic [2:0] hsize = 3'h2;
    logic [31:0] haddr = 32'h0, hwdata = 32'h0, rd, hrdata;
    logic hreadyout, hresp, resetPinN, haltStop, haltWait, irq;
    logic [6:0] c1;
    int num_errors = 0, tests_run = 0, cyc = 0, n, k;
    sfwdg_top #(.STEP_LEN(4), .PULSE_LEN(12)) dut (.sys_clk, .rst, .clkEn, .hsel,
        .haddr, .htrans, .hwrite, .hsize, .hwdata, .hready(hreadyout), .hrdata, .hreadyout,
        .hresp, .hardwiredActivationOption, .externalHaltControlOption, .stopRequest,
        .wakeInterrupt, .nmiPin, .resetPinN, .haltStop, .haltWait, .irq);
    initial forever #20 sys_clk = ~sys_clk;
    always @(posedge sys_clk) begin
        cyc++;
        if (cyc == 20000) begin
            num_errors++;
            wrap_up();
        end
    end
    ////////////////////////////////////////
    task chk(input logic ok, input string m);
        tests_run++;
        if (ok !== 1'b1) begin
            num_errors++;
            $display("BAD %0t %s", $time, m);
        end
    endtask : chk
    task wt(input int c);
        repeat (c) @(posedge sys_clk);
    endtask : wt
    task bus(input logic w, input logic [31:0] a, input logic [31:0] d);
        hsel <= 1; haddr <= a; htrans <= 2'h2; hwrite <= w;
        do @(posedge sys_clk); while (hreadyout !== 1'b1);
        hsel <= 0; htrans <= 2'h0; hwdata <= d;
        do @(posedge sys_clk); while (hreadyout !== 1'b1);
        rd = hrdata;
    endtask : bus
    task rstw(input logic h, input logic e);
        hardwiredActivationOption <= h; externalHaltControlOption <= e; rst <= 1;
        wt(4); rst <= 0; wt(4);
    endtask : rstw
    task waitlow();
        n = 0;
        while (resetPinN !== 1'b0 && n < 40) begin wt(1); n++; end
        k = 0;
        while (resetPinN === 1'b0 && k < 40) begin wt(1); k++; end
    endtask : waitlow
    // reversed countdown bits back to {alive, count}
    function logic [6:0] dec(input logic [7:0] g);
        return {g[1], g[2], g[3], g[4], g[5], g[6], g[7]};
    endfunction : dec
    ////////////////////////////////////////
    task t_timer();
        // read at the first edge after release, before the first step
        hardwiredActivationOption <= 0; externalHaltControlOption <= 0; rst <= 1;
        wt(4); rst <= 0;
        bus(0, 32'hd8, 0); chk(rd === 32'hfe, "reset value");
        bus(1, 32'hd8, 32'hfe); bus(0, 32'hd8, 0); c1 = dec(rd[7:0]); wt(40);
        bus(0, 32'hd8, 0); n = c1 - dec(rd[7:0]);
        chk(n == 10 || n == 11, "step rate");
        c1 = dec(rd[7:0]); bus(0, 32'hd8, 0); n = c1 - dec(rd[7:0]);
        chk(n == 0 || n == 1, "double read");
        c1 = dec(rd[7:0]); clkEn <= 0; wt(40); clkEn <= 1; bus(0, 32'hd8, 0);
        n = c1 - dec(rd[7:0]); chk(n == 0 || n == 1, "clock enable freeze");
        stopRequest <= 1; wt(4);
        chk(haltStop === 1'b1 && haltWait === 1'b0, "stop disabled");
        stopRequest <= 0; wt(2);
        bus(0, 32'h10, 0); chk(rd === 32'h0, "unmapped");
        $display("timer test done");
    endtask : t_timer
    task t_swreset();
        rstw(0, 0);
        bus(1, 32'hd8, 32'hff); bus(1, 32'hd8, 32'hfe); bus(0, 32'hd8, 0);
        chk(rd[0] === 1'b1, "enable sticky");
        bus(1, 32'hd8, 32'hfd); waitlow(); chk(n < 6, "sw reset");
        chk(irq === 1'b0, "masked irq");
        bus(1, 32'he0, 32'h2); wt(1); chk(irq === 1'b1, "irq raised");
        bus(0, 32'hdc, 0); chk(rd[1] === 1'b1, "status");
        wt(2); chk(irq === 1'b0, "irq cleared");
        $display("software reset test done");
    endtask : t_swreset
    task t_expire();
        rstw(0, 0);
        bus(1, 32'he0, 32'h1); bus(1, 32'hd8, 32'h83); waitlow();
        chk(n >= 5 && n <= 12, "expiry time");
        chk(k == 12, "pulse width");
        chk(irq === 1'b1, "expire irq");
        $display("expiry test done");
    endtask : t_expire
    task t_halt();
        rstw(1, 0);
        bus(1, 32'hd8, 32'hfe); bus(0, 32'hd8, 0); chk(rd[0] === 1'b1, "hw enable");
        stopRequest <= 1; wt(4);
        chk(haltWait === 1'b1 && haltStop === 1'b0, "stop as wait");
        bus(0, 32'hd8, 0); c1 = dec(rd[7:0]); wt(12); bus(0, 32'hd8, 0);
        chk(dec(rd[7:0]) != c1, "wait counts");
        stopRequest <= 0; rstw(1, 1); stopRequest <= 1; wt(4);
        chk(haltWait === 1'b1, "nmi low wait");
        stopRequest <= 0; nmiPin <= 1; wt(4); stopRequest <= 1; wt(4);
        chk(haltStop === 1'b1 && haltWait === 1'b0, "nmi high stop");
        bus(0, 32'hd8, 0); c1 = dec(rd[7:0]); wt(20); bus(0, 32'hd8, 0);
        chk(dec(rd[7:0]) == c1, "frozen");
        wakeInterrupt <= 1; stopRequest <= 0; wt(1); wakeInterrupt <= 0; wt(20);
        bus(0, 32'hd8, 0); chk(dec(rd[7:0]) != c1, "resumed");
        nmiPin <= 0;
        $display("halt test done");
    endtask : t_halt
    task wrap_up();
        $display("checks %0d errors %0d", tests_run, num_errors);
        if (num_errors == 0 && tests_run > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask : wrap_up
    initial begin
        t_timer();
        t_swreset();
        t_expire();
        t_halt();
        wrap_up();
    end
endmodule : sfwdg_top_tb
bind sfwdg_top sfwdg_assertions #(.PULSE_LEN(PULSE_LEN)) chk_i (.sys_clk, .rst, .hresp,
    .hreadyout, .resetPinN, .haltStop, .haltWait, .stopRequest);
`default_nettype wire
